// ===== hdl/spdr_pkg.sv
// constants shared by the speed ramp and speed error block
`default_nettype none
package spdr_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRE_REF = 8'h04;
  localparam logic [7:0] OFS_TIME0 = 8'h08;
  localparam logic [7:0] OFS_P_GAIN = 8'h2c;
  localparam logic [7:0] OFS_IR_COMP = 8'h30;
  localparam logic [7:0] OFS_FILT = 8'h34;
  localparam logic [7:0] OFS_MAX_SPEED = 8'h38;
  localparam logic [7:0] OFS_POST_RAMP = 8'h40;
  localparam logic [7:0] OFS_SPEED_ERR = 8'h44;
  localparam logic [7:0] OFS_LOOP_OUT = 8'h48;
  localparam logic [7:0] OFS_ERR_INTEG = 8'h4c;
  localparam logic [7:0] OFS_IR_OUT = 8'h50;
  localparam logic [7:0] OFS_SPEED_RPM = 8'h54;
  localparam logic [7:0] OFS_FEEDBACK = 8'h58;

  // ---------------------------------------------------------------
  // control word fields
  // ---------------------------------------------------------------
  localparam int CTRL_RAMP_EN = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_INCH_EN = 2;
  localparam int CTRL_SCALE = 3;
  localparam int CTRL_GROUP = 4;
  localparam int CTRL_SEL0 = 8;
  localparam int CTRL_DIG_FB = 12;
  localparam int CTRL_ARMV_FB = 13;
  localparam logic [15:0] CTRL_RESET = 16'h2001;

  // ---------------------------------------------------------------
  // ramp time table: kinds 0..3 are fwd accel, fwd decel, rev decel, rev accel
  // ---------------------------------------------------------------
  localparam int NUM_TIMES = 9;
  localparam int TIME_G2_BASE = 4;
  localparam int TIME_INCH = 8;
  localparam logic [10:0] TIME_G1_RESET = 11'h032;
  localparam logic [10:0] TIME_G2_RESET = 11'h064;
  localparam logic [10:0] TIME_INCH_RESET = 11'h064;
  localparam logic [10:0] TIME_MAX = 11'h7cf;

  // ---------------------------------------------------------------
  // value ranges and loop scaling
  // ---------------------------------------------------------------
  localparam logic signed [11:0] REF_MAX = 12'sh3e8;
  localparam logic signed [11:0] RPM_MAX = 12'sh7cf;
  localparam logic signed [23:0] FULL_SCALE = 24'sh0003e8;
  localparam logic [7:0] P_GAIN_RESET = 8'h50;
  localparam logic [7:0] IR_COMP_RESET = 8'h00;
  localparam logic [2:0] FILT_RESET = 3'h0;
  localparam logic [10:0] MAX_SPEED_RESET = 11'h6d6;
  localparam int P_GAIN_SHIFT = 3;
  localparam int IR_SHIFT = 11;
  localparam int INTEG_SHIFT = 12;
  localparam logic signed [23:0] INTEG_LIMIT = 24'sh3e8000;

  // ---------------------------------------------------------------
  // timing: one reference unit per tenth-second of ramp time over full scale
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int RAMP_UNIT_NS = 100000;
  localparam int RAMP_UNIT_CYC = RAMP_UNIT_NS / CLK_PERIOD_NS;
  localparam int RAMP_SCALE = 10;

  typedef enum {SPDR_RAMP_BYPASS, SPDR_RAMP_HOLD, SPDR_RAMP_RUN} spdr_mode_e;

endpackage
`default_nettype wire

// ===== hdl/spdr_ramp_tick.sv
// period counter that paces ramp steps
`timescale 1ns/10ps
`default_nettype none
module spdr_ramp_tick #(
  parameter int CNT_W = 26
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [CNT_W-1:0] period_in,
  input wire logic restart_in,
  output logic tick_out
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // ---------------------------------------------------------------
  // count up to period minus one, pulse, wrap
  // ---------------------------------------------------------------
  assign tick_out = !restart_in && (count + CNT_W'(1) >= period_in);

  always_comb begin
    next_count = count + CNT_W'(1);
    if (restart_in || tick_out) begin
      next_count = '0;
    end
  end

  // counter register
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  a_tick_spacing: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tick_out && period_in > CNT_W'(1) && $stable(period_in) |=> !tick_out) // [R18]
    else $error("ramp ticks closer than the period");

endmodule
`default_nettype wire

// ===== hdl/spdr_err_filter.sv
// first-order low-pass filter for the speed error
`timescale 1ns/10ps
`default_nettype none
module spdr_err_filter #(
  parameter int W = 12,
  parameter int FRAC = 8
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic signed [W-1:0] x_in,
  input wire logic [2:0] shift_in,
  output logic signed [W-1:0] y_out
);

  logic signed [W+FRAC-1:0] acc;
  logic signed [W+FRAC-1:0] next_acc;
  logic signed [W+FRAC-1:0] x_wide;

  // ---------------------------------------------------------------
  // y moves by (x - y) / 2^shift each cycle; shift 0 passes x through
  // ---------------------------------------------------------------
  always_comb begin
    x_wide = {x_in, FRAC'(0)};
    next_acc = acc + ((x_wide - acc) >>> shift_in);
  end

  // filter state and registered output
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  assign y_out = acc[W+FRAC-1:FRAC];

endmodule
`default_nettype wire

// ===== hdl/spdr_speed_ramp_error.sv
// speed reference ramp and speed error front end with avalon register slave
//
// Summary of operation
// R01 - each ramp kind picks group 1 or 2 from its own and the common selector
// R02 - common group selector one picks group 2 for every kind, zero leaves each kind's own selector; resets to zero
// R03 - ramp enable zero passes pre-ramp reference straight through; resets to one
// R04 - ramp hold one freezes the ramp output
// R05 - ramp times span 0 to 1999 tenths; group 1 resets 50, group 2 resets 100
// R06 - ramp time is the time for a full 0 to 1000 excursion
// R07 - inch ramp time applies to jog, same range, resets to 100
// R08 - inch ramp enable one uses inch time while a jog input is active
// R09 - ramp scaling one multiplies every ramp time by ten
// R10 - post-ramp reference readable, within plus or minus 1000
// R11 - speed error is demand minus feedback, then a configurable filter
// R12 - proportional term is gain over eight; gain 0 to 255, resets 80
// R13 - feedback comes from encoder, tachometer or armature voltage
// R14 - rpm display within plus or minus 1999, scaled by maximum speed
// R15 - ir output is integral times ir setting; integral readable within 1000
// R16 - speed loop output is the current loop reference
// R17 - digital selector one picks encoder, else second picks tach or armature
// R18 - ramp moves one unit per tick, full scale in the ramp time
// R19 - growing magnitude is accel, shrinking is decel, per direction
`timescale 1ns/10ps
`default_nettype none
module spdr_speed_ramp_error #(
  parameter int CYC_PER_UNIT = spdr_pkg::RAMP_UNIT_CYC,
  parameter int CNT_W = 26
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic jog_fwd_in,
  input wire logic jog_rev_in,
  input wire logic signed [11:0] enc_fb_in,
  input wire logic signed [11:0] tach_fb_in,
  input wire logic signed [11:0] armv_fb_in,
  output logic signed [11:0] post_ramp_out,
  output logic signed [11:0] torque_ref_out,
  output logic signed [11:0] ir_comp_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic signed [11:0] clamp(input logic signed [23:0] v, input logic signed [11:0] lim);
    logic signed [23:0] l;
    l = 24'(lim);
    if (v > l) return lim;
    if (v < -l) return -lim;
    return v[11:0];
  endfunction

  function automatic logic [31:0] sext(input logic signed [11:0] v);
    return {{20{v[11]}}, v};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // reset release and jog input synchronisers
  // ---------------------------------------------------------------
  logic rst_q1;
  logic rst_n;
  logic [1:0] jog_q1;
  logic [1:0] jog_s;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // two stages on the jog pins
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      jog_q1 <= 2'h0;
      jog_s <= 2'h0;
    end else begin
      jog_q1 <= {jog_rev_in, jog_fwd_in};
      jog_s <= jog_q1;
    end
  end

  // ---------------------------------------------------------------
  // register file state
  // ---------------------------------------------------------------
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic [15:0] ctrl, next_ctrl;
  logic signed [11:0] pre_ref, next_pre_ref;
  logic [10:0] times [spdr_pkg::NUM_TIMES];
  logic [10:0] next_times [spdr_pkg::NUM_TIMES];
  logic [7:0] p_gain, next_p_gain;
  logic [7:0] ir_comp, next_ir_comp;
  logic [2:0] filt, next_filt;
  logic [10:0] max_speed, next_max_speed;
  logic [31:0] rd_word;
  logic [15:0] wr16;

  // block state visible to software
  logic signed [11:0] post_ramp, next_post_ramp;
  logic signed [11:0] err_f;
  logic signed [11:0] fb_q, next_fb_q;
  logic signed [23:0] integ_acc, next_integ_acc;
  logic signed [11:0] integral;
  logic signed [11:0] torque, next_torque;
  logic signed [11:0] ir_out, next_ir_out;
  logic signed [11:0] rpm, next_rpm;

  // ---------------------------------------------------------------
  // read multiplexer; unmapped addresses read zero
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0;
    case (avs_address_in)
      spdr_pkg::OFS_CTRL: rd_word = {16'h0, ctrl};
      spdr_pkg::OFS_PRE_REF: rd_word = sext(pre_ref);
      spdr_pkg::OFS_P_GAIN: rd_word = {24'h0, p_gain};
      spdr_pkg::OFS_IR_COMP: rd_word = {24'h0, ir_comp};
      spdr_pkg::OFS_FILT: rd_word = {29'h0, filt};
      spdr_pkg::OFS_MAX_SPEED: rd_word = {21'h0, max_speed};
      spdr_pkg::OFS_POST_RAMP: rd_word = sext(post_ramp); // [R10]
      spdr_pkg::OFS_SPEED_ERR: rd_word = sext(err_f);
      spdr_pkg::OFS_LOOP_OUT: rd_word = sext(torque);
      spdr_pkg::OFS_ERR_INTEG: rd_word = sext(integral); // [R15]
      spdr_pkg::OFS_IR_OUT: rd_word = sext(ir_out);
      spdr_pkg::OFS_SPEED_RPM: rd_word = sext(rpm);
      spdr_pkg::OFS_FEEDBACK: rd_word = sext(fb_q);
      default: rd_word = 32'h0;
    endcase
    for (int i = 0; i < spdr_pkg::NUM_TIMES; i++) begin
      if (avs_address_in == spdr_pkg::OFS_TIME0 + 8'(4 * i)) begin
        rd_word = {21'h0, times[i]};
      end
    end
  end

  // ---------------------------------------------------------------
  // bus slave: one wait cycle, write lands and read data stand on the second
  // ---------------------------------------------------------------
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;
  assign avs_readdata_out = rdata;

  always_comb begin
    wr16 = merge16(rd_word[15:0], avs_writedata_in, avs_byteenable_in);
    next_ack = (avs_read_in || avs_write_in) && !ack;
    next_rdata = rdata;
    next_ctrl = ctrl;
    next_pre_ref = pre_ref;
    next_p_gain = p_gain;
    next_ir_comp = ir_comp;
    next_filt = filt;
    next_max_speed = max_speed;
    for (int i = 0; i < spdr_pkg::NUM_TIMES; i++) begin
      next_times[i] = times[i];
    end
    if (avs_read_in && !ack) begin
      next_rdata = rd_word;
    end
    if (avs_write_in && ack) begin
      case (avs_address_in)
        spdr_pkg::OFS_CTRL: next_ctrl = wr16;
        spdr_pkg::OFS_PRE_REF: next_pre_ref = clamp(24'($signed(wr16)), spdr_pkg::REF_MAX);
        spdr_pkg::OFS_P_GAIN: next_p_gain = wr16[7:0]; // [R12]
        spdr_pkg::OFS_IR_COMP: next_ir_comp = wr16[7:0];
        spdr_pkg::OFS_FILT: next_filt = wr16[2:0];
        spdr_pkg::OFS_MAX_SPEED: next_max_speed = wr16[10:0];
        default: next_ctrl = ctrl;
      endcase
      for (int i = 0; i < spdr_pkg::NUM_TIMES; i++) begin
        if (avs_address_in == spdr_pkg::OFS_TIME0 + 8'(4 * i)) begin
          next_times[i] = (wr16 > 16'(spdr_pkg::TIME_MAX)) ? spdr_pkg::TIME_MAX : wr16[10:0]; // [R05]
        end
      end
    end
  end

  // register file flops; reset values per field
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      rdata <= 32'h0;
      ctrl <= spdr_pkg::CTRL_RESET; // [R02] [R03] [R08] [R09]
      pre_ref <= 12'sh000;
      p_gain <= spdr_pkg::P_GAIN_RESET; // [R12]
      ir_comp <= spdr_pkg::IR_COMP_RESET;
      filt <= spdr_pkg::FILT_RESET;
      max_speed <= spdr_pkg::MAX_SPEED_RESET;
      for (int i = 0; i < spdr_pkg::NUM_TIMES; i++) begin
        times[i] <= (i < spdr_pkg::TIME_G2_BASE) ? spdr_pkg::TIME_G1_RESET : spdr_pkg::TIME_G2_RESET; // [R05]
      end
      times[spdr_pkg::TIME_INCH] <= spdr_pkg::TIME_INCH_RESET; // [R07]
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      ctrl <= next_ctrl;
      pre_ref <= next_pre_ref;
      p_gain <= next_p_gain;
      ir_comp <= next_ir_comp;
      filt <= next_filt;
      max_speed <= next_max_speed;
      for (int i = 0; i < spdr_pkg::NUM_TIMES; i++) begin
        times[i] <= next_times[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // ramp time selection
  // ---------------------------------------------------------------
  spdr_pkg::spdr_mode_e mode;
  logic up, jog_active, use_g2, tick, restart;
  logic [1:0] kind;
  logic [3:0] idx;
  logic [CNT_W-1:0] period;

  always_comb begin
    up = pre_ref > post_ramp;
    jog_active = ctrl[spdr_pkg::CTRL_INCH_EN] && (jog_s != 2'h0);
    // growing magnitude accelerates, shrinking decelerates [R19]
    if (up) begin
      kind = (post_ramp >= 12'sh000) ? 2'h0 : 2'h2;
    end else begin
      kind = (post_ramp > 12'sh000) ? 2'h1 : 2'h3;
    end
    use_g2 = ctrl[spdr_pkg::CTRL_GROUP] || ctrl[spdr_pkg::CTRL_SEL0 + int'(kind)]; // [R01] [R02]
    idx = use_g2 ? 4'(int'(kind) + spdr_pkg::TIME_G2_BASE) : {2'h0, kind};
    if (jog_active) begin
      idx = 4'(spdr_pkg::TIME_INCH); // [R07] [R08]
    end
    // cycles per reference unit: full scale 1000 units over the ramp time [R06]
    period = CNT_W'(times[idx]) * CNT_W'(CYC_PER_UNIT);
    if (ctrl[spdr_pkg::CTRL_SCALE]) begin
      period = period * CNT_W'(spdr_pkg::RAMP_SCALE); // [R09]
    end
    if (!ctrl[spdr_pkg::CTRL_RAMP_EN]) begin
      mode = spdr_pkg::SPDR_RAMP_BYPASS;
    end else if (ctrl[spdr_pkg::CTRL_HOLD]) begin
      mode = spdr_pkg::SPDR_RAMP_HOLD;
    end else begin
      mode = spdr_pkg::SPDR_RAMP_RUN;
    end
    restart = (mode != spdr_pkg::SPDR_RAMP_RUN) || (post_ramp == pre_ref);
  end

  spdr_ramp_tick #(
    .CNT_W(CNT_W)
  ) u_tick (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .period_in(period),
    .restart_in(restart),
    .tick_out(tick)
  );

  // ---------------------------------------------------------------
  // ramp output
  // ---------------------------------------------------------------
  always_comb begin
    next_post_ramp = post_ramp;
    unique case (mode)
      spdr_pkg::SPDR_RAMP_BYPASS: next_post_ramp = pre_ref; // [R03]
      spdr_pkg::SPDR_RAMP_HOLD: next_post_ramp = post_ramp; // [R04]
      spdr_pkg::SPDR_RAMP_RUN: begin
        if (period == '0) begin
          next_post_ramp = pre_ref;
        end else if (tick) begin
          next_post_ramp = up ? post_ramp + 12'sh001 : post_ramp - 12'sh001; // [R18]
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      post_ramp <= 12'sh000;
    end else begin
      post_ramp <= next_post_ramp;
    end
  end

  assign post_ramp_out = post_ramp;

  // ---------------------------------------------------------------
  // feedback select, speed error and velocity loop
  // ---------------------------------------------------------------
  logic signed [11:0] fb_sel, err_raw, prop_c;
  logic signed [23:0] prop, ir_prod, rpm_prod;

  always_comb begin
    // encoder, else tach or armature voltage [R13] [R17]
    if (ctrl[spdr_pkg::CTRL_DIG_FB]) begin
      fb_sel = enc_fb_in;
    end else begin
      fb_sel = ctrl[spdr_pkg::CTRL_ARMV_FB] ? armv_fb_in : tach_fb_in;
    end
    err_raw = clamp(24'(post_ramp) - 24'(fb_sel), spdr_pkg::REF_MAX); // [R11]
    next_fb_q = fb_sel;
    next_integ_acc = integ_acc + 24'(err_f);
    if (next_integ_acc > spdr_pkg::INTEG_LIMIT) next_integ_acc = spdr_pkg::INTEG_LIMIT;
    if (next_integ_acc < -spdr_pkg::INTEG_LIMIT) next_integ_acc = -spdr_pkg::INTEG_LIMIT;
    prop = (24'(err_f) * $signed({16'h0, p_gain})) >>> spdr_pkg::P_GAIN_SHIFT; // [R12]
    prop_c = clamp(prop, spdr_pkg::REF_MAX);
    next_torque = clamp(24'(prop_c) + 24'(integral), spdr_pkg::REF_MAX); // [R16]
    ir_prod = (24'(integral) * $signed({16'h0, ir_comp})) >>> spdr_pkg::IR_SHIFT;
    next_ir_out = clamp(ir_prod, spdr_pkg::REF_MAX); // [R15]
    rpm_prod = (24'(fb_q) * $signed({13'h0, max_speed})) / spdr_pkg::FULL_SCALE;
    next_rpm = clamp(rpm_prod, spdr_pkg::RPM_MAX); // [R14]
  end

  spdr_err_filter #(
    .W(12),
    .FRAC(8)
  ) u_filt (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .x_in(err_raw),
    .shift_in(filt),
    .y_out(err_f)
  );

  assign integral = integ_acc[spdr_pkg::INTEG_SHIFT+11:spdr_pkg::INTEG_SHIFT];

  // loop registers
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      fb_q <= 12'sh000;
      integ_acc <= 24'sh000000;
      torque <= 12'sh000;
      ir_out <= 12'sh000;
      rpm <= 12'sh000;
    end else begin
      fb_q <= next_fb_q;
      integ_acc <= next_integ_acc;
      torque <= next_torque;
      ir_out <= next_ir_out;
      rpm <= next_rpm;
    end
  end

  assign torque_ref_out = torque;
  assign ir_comp_out = ir_out;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_bypass_follows: assert property (@(posedge mclk_in) disable iff (!rst_n) // [R03]
    !ctrl[spdr_pkg::CTRL_RAMP_EN] |=> post_ramp == $past(pre_ref))
    else $error("bypassed ramp does not follow the reference");
  a_hold_freezes: assert property (@(posedge mclk_in) disable iff (!rst_n) // [R04]
    ctrl[spdr_pkg::CTRL_RAMP_EN] && ctrl[spdr_pkg::CTRL_HOLD] |=> $stable(post_ramp))
    else $error("held ramp output moved");
  a_ramp_unit_step: assert property (@(posedge mclk_in) disable iff (!rst_n) // [R18]
    mode == spdr_pkg::SPDR_RAMP_RUN && period != '0 |=>
    (post_ramp - $past(post_ramp) <= 12'sh001) && ($past(post_ramp) - post_ramp <= 12'sh001))
    else $error("ramp stepped more than one unit");
  a_post_range: assert property (@(posedge mclk_in) disable iff (!rst_n) // [R10]
    post_ramp <= spdr_pkg::REF_MAX && post_ramp >= -spdr_pkg::REF_MAX)
    else $error("post-ramp reference out of range");
  a_group_two: assert property (@(posedge mclk_in) disable iff (!rst_n) // [R02]
    ctrl[spdr_pkg::CTRL_GROUP] && !jog_active |-> idx >= 4'(spdr_pkg::TIME_G2_BASE))
    else $error("group two not selected");
  a_jog_time: assert property (@(posedge mclk_in) disable iff (!rst_n) // [R08]
    jog_active |-> idx == 4'(spdr_pkg::TIME_INCH))
    else $error("jog ramp time not used");
  a_decel_fwd: assert property (@(posedge mclk_in) disable iff (!rst_n) // [R19]
    !up && post_ramp > 12'sh000 && !jog_active && !use_g2 |-> idx == 4'h1)
    else $error("forward decel time not used");
  a_time_range: assert property (@(posedge mclk_in) disable iff (!rst_n) // [R05]
    times[0] <= spdr_pkg::TIME_MAX && times[spdr_pkg::TIME_INCH] <= spdr_pkg::TIME_MAX)
    else $error("ramp time above range");
  a_bus_one_wait: assert property (@(posedge mclk_in) disable iff (!rst_n)
    avs_waitrequest_out ##1 (avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("bus wait longer than one cycle");
  a_torque_range: assert property (@(posedge mclk_in) disable iff (!rst_n) // [R16]
    torque <= spdr_pkg::REF_MAX && torque >= -spdr_pkg::REF_MAX && integral <= spdr_pkg::REF_MAX)
    else $error("loop output out of range");

endmodule
`default_nettype wire

// ===== sim/spdr_fb_model.sv
// far side model: speed feedback sources and current loop input
`timescale 1ns/10ps
`default_nettype none
module spdr_fb_model #(
  parameter logic signed [11:0] ENC = 12'sh064,
  parameter logic signed [11:0] TACH = 12'sh0c8,
  parameter logic signed [11:0] ARMV = 12'sh12c
) (
  input wire logic mclk_in,
  input wire logic signed [11:0] torque_ref_in,
  output logic signed [11:0] enc_fb_out,
  output logic signed [11:0] tach_fb_out,
  output logic signed [11:0] armv_fb_out,
  output logic signed [11:0] cur_ref_out
);
  // distinct steady levels so the chosen source shows in the error
  assign enc_fb_out = ENC;
  assign tach_fb_out = TACH;
  assign armv_fb_out = ARMV;
  // current loop takes the speed loop output as its reference
  always_ff @(posedge mclk_in) begin
    cur_ref_out <= torque_ref_in;
  end
endmodule
`default_nettype wire

// ===== sim/spdr_speed_ramp_error_tb.sv
// bench for the speed ramp and speed error block
`timescale 1ns/10ps
`default_nettype none
module spdr_speed_ramp_error_tb;
  logic mclk_in, rst_n_in, rd_req, wr_req, wait_o, jog_f, jog_r;
  logic [7:0] adr;
  logic [31:0] wdata, rdata, got;
  logic signed [11:0] enc, tach, armv, post, torque, ir, cur;
  int n_mismatch = 0;
  int checks_done = 0;
  // ----------------------------------------
  // clock, device and far side
  // ----------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  spdr_speed_ramp_error #(.CYC_PER_UNIT(2)) i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .avs_address_in(adr), .avs_read_in(rd_req), .avs_write_in(wr_req), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
    .jog_fwd_in(jog_f), .jog_rev_in(jog_r), .enc_fb_in(enc), .tach_fb_in(tach), .armv_fb_in(armv),
    .post_ramp_out(post), .torque_ref_out(torque), .ir_comp_out(ir));
  spdr_fb_model i_fb (.mclk_in(mclk_in), .torque_ref_in(torque), .enc_fb_out(enc),
    .tach_fb_out(tach), .armv_fb_out(armv), .cur_ref_out(cur));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    adr <= a;
    wdata <= d;
    wr_req <= w;
    rd_req <= !w;
    @(posedge mclk_in);
    while (wait_o !== 1'b0) @(posedge mclk_in);
    got = rdata;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(got, e);
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // defaults: ctrl, fwd accel g1, fwd accel g2, inch, p gain, unmapped
  task automatic t_reset();
    logic [7:0] a[6] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h2c, 8'hfc};
    logic [31:0] e[6] = '{32'h2001, 32'h32, 32'h64, 32'h64, 32'h50, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd_chk(a[i], e[i]);
    end
    $display("test reset values done");
  endtask
  // each feedback source in bypass: error is demand minus feedback
  task automatic t_feedback();
    logic [31:0] c[3] = '{32'h1000, 32'h0000, 32'h2000};
    logic [31:0] f[3] = '{32'h64, 32'hc8, 32'h12c};
    bus(1'b1, 8'h04, 32'h12c);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h00, c[i]);
      repeat (4) @(posedge mclk_in);
      rd_chk(8'h58, f[i]);
      rd_chk(8'h44, 32'h12c - f[i]);
      chk(32'(post), 32'h12c);
    end
    $display("test feedback and bypass done");
  endtask
  // ramp pace, group select, hold and scaling
  task automatic t_ramp();
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b1, 8'h00, 32'h2001);
    bus(1'b1, 8'h04, 32'h136);
    repeat (8) @(posedge mclk_in);
    chk(32'(post), 32'h12f);
    repeat (20) @(posedge mclk_in);
    chk(32'(post), 32'h136);
    bus(1'b1, 8'h00, 32'h2011);
    bus(1'b1, 8'h04, 32'h140);
    repeat (3) @(posedge mclk_in);
    rd_chk(8'h40, 32'h140);
    bus(1'b1, 8'h00, 32'h2013);
    bus(1'b1, 8'h04, 32'h14a);
    repeat (6) @(posedge mclk_in);
    chk(32'(post), 32'h140);
    bus(1'b1, 8'h00, 32'h2009);
    repeat (30) @(posedge mclk_in);
    chk(32'(post), 32'h141);
    $display("test ramp done");
  endtask
  // speed loop: saturate the integral, then gain over eight and ir scaling
  task automatic t_loop();
    bus(1'b1, 8'h0c, 32'hfff);
    rd_chk(8'h0c, 32'h7cf);
    bus(1'b1, 8'h2c, 32'h10);
    bus(1'b1, 8'h30, 32'hff);
    bus(1'b1, 8'h00, 32'h2000);
    bus(1'b1, 8'h04, 32'hfffffc18);
    repeat (4300) @(posedge mclk_in);
    rd_chk(8'h4c, 32'hfffffc18);
    chk(32'(torque), 32'hfffffc18);
    chk(32'(ir), 32'hffffff83);
    bus(1'b1, 8'h04, 32'h12c);
    bus(1'b1, 8'h00, 32'h1000);
    repeat (4) @(posedge mclk_in);
    chk(32'(torque), 32'hfffffda8);
    chk(32'(cur), 32'hfffffda8);
    rd_chk(8'h54, 32'haf);
    $display("test speed loop done");
  endtask
  // inch ramp: either jog pin swaps in the inch time
  task automatic t_jog();
    bus(1'b1, 8'h08, 32'h32);
    bus(1'b1, 8'h28, 32'h1);
    bus(1'b1, 8'h00, 32'h2005);
    jog_r <= 1'b1;
    bus(1'b1, 8'h04, 32'h136);
    repeat (8) @(posedge mclk_in);
    chk(32'(post), 32'h12f);
    jog_r <= 1'b0;
    jog_f <= 1'b1;
    repeat (8) @(posedge mclk_in);
    chk(32'(post), 32'h133);
    jog_f <= 1'b0;
    $display("test inch ramp done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_n_in = 1'b0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    adr = 8'h0;
    wdata = 32'h0;
    jog_f = 1'b0;
    jog_r = 1'b0;
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    t_reset();
    t_feedback();
    t_ramp();
    t_loop();
    t_jog();
    final_report();
  end
  initial begin
    #(6000 * 50);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
